// ---- rtl/mdc_cfg.svh ----
// modem dial control: offsets, codes, reset values and timing counts
`ifndef MDC_CFG_SVH
`define MDC_CFG_SVH

// ------------------------------------------------------------------
// byte offsets relative to the control block base
// ------------------------------------------------------------------
`define MDC_OFF_CMD 12'h000
`define MDC_OFF_RES 12'h004
`define MDC_OFF_STR 12'h008
`define MDC_OFF_STR_END 12'h058
`define MDC_OFF_CFG 12'h080
`define MDC_OFF_IST 12'h084
`define MDC_OFF_IMASK 12'h088
`define MDC_OFF_SLOT 12'h400
`define MDC_OFF_SLOT_END 12'h720

// ------------------------------------------------------------------
// sizes
// ------------------------------------------------------------------
`define MDC_STR_WORDS 20
`define MDC_STR_CHARS 6'h28
`define MDC_SLOTS 10
`define MDC_SLOT_WORDS 200

// ------------------------------------------------------------------
// command codes
// ------------------------------------------------------------------
`define MDC_CMD_IDLE 16'h0000
`define MDC_CMD_DIAL_LO 16'h0001
`define MDC_CMD_DIAL_HI 16'h000A
`define MDC_CMD_DIAL_USER 16'h000B
`define MDC_CMD_INIT_LO 16'h0065
`define MDC_CMD_INIT_HI 16'h006E
`define MDC_CMD_INIT_USER 16'h006F
`define MDC_CMD_HANGUP 16'h00FF

// ------------------------------------------------------------------
// result codes
// ------------------------------------------------------------------
`define MDC_RES_OK 16'h0000
`define MDC_RES_DIALLING 16'h0001
`define MDC_RES_CONNECTED 16'h0002
`define MDC_RES_RING 16'h0003
`define MDC_RES_NO_CONN 16'h0065
`define MDC_RES_LOST_CARRIER 16'h0066
`define MDC_RES_NO_DIALTONE 16'h0067
`define MDC_RES_DIAL_FAIL 16'h0068
`define MDC_RES_IDLE_HUP 16'h0069
`define MDC_RES_BAD_CMD 16'h006A

// ------------------------------------------------------------------
// configuration word: [9:0] idle timeout seconds, [16] tone dialling
// ------------------------------------------------------------------
`define MDC_CFG_TONE_BIT 16
`define MDC_TMO_RST 10'h01E
`define MDC_TMO_MIN 10'h005
`define MDC_TMO_MAX 10'h258
`define MDC_TONE_RST 1'b1

// ------------------------------------------------------------------
// interrupt bit positions
// ------------------------------------------------------------------
`define MDC_IRQ_DONE 0
`define MDC_IRQ_CONN 1
`define MDC_IRQ_RING 2
`define MDC_IRQ_ERR 3
`define MDC_IRQ_IDLE 4
`define MDC_IRQ_W 5

// ------------------------------------------------------------------
// characters sent to the modem
// ------------------------------------------------------------------
`define MDC_CH_A 8'h41
`define MDC_CH_T 8'h54
`define MDC_CH_D 8'h44
`define MDC_CH_P 8'h50
`define MDC_CH_CR 8'h0D

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define MDC_SEC_NS 1000000000
`define MDC_CLK_NS 20
`define MDC_CYC_PER_SEC (`MDC_SEC_NS / `MDC_CLK_NS)

`endif

// ---- rtl/mdc_pkg.sv ----
// modem dial control: shared types
package mdc_pkg;

	typedef enum logic [1:0] {
		FS_IDLE,
		FS_SEND,
		FS_WAIT
	} mdc_fsm_t;

	// one-cycle indications decoded from the modem's answers
	typedef struct packed {
		logic ok;
		logic error;
		logic connect;
		logic ring;
		logic no_carrier;
		logic no_dialtone;
		logic dial_fail;
		logic activity;
	} mdc_modem_ev_t;

	typedef struct packed {
		mdc_fsm_t fsm;
		logic ack;
		logic [31:0] rdat;
		logic [15:0] cmd;
		logic [15:0] res;
		logic [19:0][15:0] str;
		logic [199:0][15:0] slots;
		logic [9:0] tmo;
		logic tone;
		logic [4:0] ist;
		logic [4:0] imask;
		logic hold;
		logic online;
		logic is_dial;
		logic user_src;
		logic [3:0] slot;
		logic [5:0] st;
		logic [7:0] txd;
		logic txv;
		logic last;
		logic [9:0] secs;
	} mdc_state_t;

endpackage

// ---- rtl/mdc_tick.sv ----
// modem dial control: one-second tick prescaler
`timescale 1ns/100ps
`include "mdc_cfg.svh"

module mdc_tick #(
	parameter int CYC_PER_SEC = `MDC_CYC_PER_SEC
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic clear_i, // restart the second
	output logic tick_o // one-cycle pulse per second
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;

	always_comb begin
		if (clear_i || tick_o) begin
			cnt_nxt = 32'h0;
		end else begin
			cnt_nxt = cnt_r + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 32'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign tick_o = (cnt_r == 32'(CYC_PER_SEC - 1));
endmodule

// ---- rtl/mdc_top.sv ----
// modem dial control: command interpreter with wishbone register block
// Function
// (R1) word 0 commands: 0 idle, 255 hang up
// (R2) commands 1-10 dial stored number slot
// (R3) command 11 dials string from word two
// (R4) string: 40 chars, two per word, 20 words
// (R5) zero word ends string; stop reading there
// (R6) commands 101-110 send stored init slot
// (R7) command 111 sends init string from words
// (R8) init strings passed to modem unchanged
// (R9) result word: 0 success, 101 no connection
// (R10) report dialling, connected, ring, error codes
// (R11) hang up idle line after set seconds
// (R12) dial by pulse or tone per setting
// (R13) control block sits at configurable base word
// (R14) controller writes string first, awaits final status
`timescale 1ns/100ps
`include "mdc_cfg.svh"

module mdc_top
	import mdc_pkg::*;
#(
	parameter logic [31:0] CTRL_BASE = 32'h0000_0000,
	parameter int CYC_PER_SEC = `MDC_CYC_PER_SEC
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [31:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire mdc_modem_ev_t modem_ev_i, // modem answer pulses
	output logic [7:0] tx_data_o, // character to modem
	output logic tx_valid_o, // character valid
	input wire logic tx_ready_i, // modem takes character
	output logic line_hold_o, // keep line off hook
	output logic tone_mode_o, // 1 tone, 0 pulse dialling
	output logic online_o, // connection established
	output logic irq_o // interrupt, high level
);
	mdc_state_t s;
	mdc_state_t n;
	logic tick;
	logic sec_clr;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = d[7:0];
		end
		if (sel[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// character c of the active source, low byte of each word first
	function automatic logic [7:0] char_at(input mdc_state_t q, input logic [5:0] c);
		logic [15:0] w;
		logic [7:0] idx;
		idx = ({4'h0, q.slot} * 8'h14) + {3'b000, c[5:1]};
		if (q.user_src) begin
			w = q.str[c[5:1]]; // (R3)
		end else begin
			w = q.slots[idx]; // (R2)
		end
		return c[0] ? w[15:8] : w[7:0]; // (R4)
	endfunction

	// byte for step st: dial prefix, then string, 0 marks end of string
	function automatic logic [7:0] step_byte(input mdc_state_t q, input logic [5:0] st);
		logic [5:0] c;
		logic [7:0] b;
		c = st - 6'd4;
		case (st)
			6'd0: b = `MDC_CH_A;
			6'd1: b = `MDC_CH_T;
			6'd2: b = `MDC_CH_D;
			6'd3: b = q.tone ? `MDC_CH_T : `MDC_CH_P; // (R12)
			default: begin
				if (c < `MDC_STR_CHARS) begin
					b = char_at(q, c); // (R8)
				end else begin
					b = 8'h00; // (R4)
				end
			end
		endcase
		return b;
	endfunction

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	logic [31:0] off;
	logic [11:0] wa;
	logic in_blk;
	logic req;
	logic wr;
	logic [4:0] str_i;
	logic [7:0] slot_i;
	logic [31:0] rd_val;
	logic [11:0] str_off;
	logic [11:0] slot_off;

	always_comb begin
		off = wb_adr_i - CTRL_BASE; // (R13)
		wa = {off[11:2], 2'b00};
		in_blk = (off[31:12] == 20'h0);
		req = wb_cyc_i && wb_stb_i;
		wr = req && s.ack && wb_we_i;
		str_off = (wa - `MDC_OFF_STR) >> 2;
		slot_off = (wa - `MDC_OFF_SLOT) >> 2;
		str_i = str_off[4:0];
		slot_i = slot_off[7:0];
		rd_val = 32'h0;
		if (in_blk) begin
			if (wa == `MDC_OFF_CMD) begin
				rd_val = {16'h0, s.cmd};
			end else if (wa == `MDC_OFF_RES) begin
				rd_val = {16'h0, s.res};
			end else if (wa >= `MDC_OFF_STR && wa < `MDC_OFF_STR_END) begin
				rd_val = {16'h0, s.str[str_i]};
			end else if (wa == `MDC_OFF_CFG) begin
				rd_val = {15'h0, s.tone, 6'h0, s.tmo};
			end else if (wa == `MDC_OFF_IST) begin
				rd_val = {27'h0, s.ist};
			end else if (wa == `MDC_OFF_IMASK) begin
				rd_val = {27'h0, s.imask};
			end else if (wa >= `MDC_OFF_SLOT && wa < `MDC_OFF_SLOT_END) begin
				rd_val = {16'h0, s.slots[slot_i]};
			end
		end
	end

	// ------------------------------------------------------------------
	// state update
	// ------------------------------------------------------------------
	logic [4:0] ev;
	logic [4:0] w1c;
	logic [15:0] c;
	logic [9:0] tmo_w;
	logic [7:0] b;
	logic start;
	logic fin;

	always_comb begin
		n = s;
		ev = 5'h0;
		w1c = 5'h0;
		sec_clr = 1'b0;
		start = 1'b0;
		fin = 1'b0;
		c = s.cmd;
		tmo_w = wb_dat_i[9:0];
		b = 8'h00;

		// single-wait-state slave: ack one cycle after the request, then drops
		n.ack = req && !s.ack;
		if (req && !s.ack) begin
			n.rdat = rd_val;
		end

		if (wr && in_blk) begin
			// command word is locked while a command runs
			if (wa == `MDC_OFF_CMD && s.fsm == FS_IDLE) begin
				n.cmd = merge16(s.cmd, wb_dat_i, wb_sel_i);
			end else if (wa >= `MDC_OFF_STR && wa < `MDC_OFF_STR_END) begin
				n.str[str_i] = merge16(s.str[str_i], wb_dat_i, wb_sel_i); // (R4)
			end else if (wa == `MDC_OFF_CFG) begin
				if (wb_sel_i[1:0] == 2'b11) begin
					// out-of-range timeouts clamp rather than fault
					if (tmo_w < `MDC_TMO_MIN) begin
						n.tmo = `MDC_TMO_MIN; // (R11)
					end else if (tmo_w > `MDC_TMO_MAX) begin
						n.tmo = `MDC_TMO_MAX; // (R11)
					end else begin
						n.tmo = tmo_w;
					end
				end
				if (wb_sel_i[2]) begin
					n.tone = wb_dat_i[`MDC_CFG_TONE_BIT]; // (R12)
				end
			end else if (wa == `MDC_OFF_IST && wb_sel_i[0]) begin
				w1c = wb_dat_i[4:0];
			end else if (wa == `MDC_OFF_IMASK && wb_sel_i[0]) begin
				n.imask = wb_dat_i[4:0];
			end else if (wa >= `MDC_OFF_SLOT && wa < `MDC_OFF_SLOT_END) begin
				n.slots[slot_i] = merge16(s.slots[slot_i], wb_dat_i, wb_sel_i);
			end
		end

		// seconds since last activity, saturating
		if (tick && s.secs != 10'h3FF) begin
			n.secs = s.secs + 10'h1;
		end

		case (s.fsm)
			FS_IDLE: begin
				if (c == `MDC_CMD_IDLE) begin
					// waiting for a command (R1)
				end else if (c == `MDC_CMD_HANGUP) begin
					n.hold = 1'b0; // (R1)
					n.online = 1'b0;
					n.res = `MDC_RES_OK; // (R9)
					n.cmd = `MDC_CMD_IDLE;
					ev[`MDC_IRQ_DONE] = 1'b1;
				end else if (c >= `MDC_CMD_DIAL_LO && c <= `MDC_CMD_DIAL_USER) begin
					start = 1'b1;
					n.is_dial = 1'b1;
					n.user_src = (c == `MDC_CMD_DIAL_USER); // (R3)
					n.slot = 4'(c - `MDC_CMD_DIAL_LO); // (R2)
					n.st = 6'd0;
					n.hold = 1'b1;
					n.res = `MDC_RES_DIALLING; // (R10)
				end else if (c >= `MDC_CMD_INIT_LO && c <= `MDC_CMD_INIT_USER) begin
					start = 1'b1;
					n.is_dial = 1'b0;
					n.user_src = (c == `MDC_CMD_INIT_USER); // (R7)
					n.slot = 4'(c - `MDC_CMD_INIT_LO); // (R6)
					n.st = 6'd4;
				end else begin
					n.res = `MDC_RES_BAD_CMD;
					n.cmd = `MDC_CMD_IDLE;
					ev[`MDC_IRQ_ERR] = 1'b1;
				end
				if (start) begin
					n.fsm = FS_SEND;
				end
				// unsolicited ring and carrier loss while no command runs
				if (modem_ev_i.ring) begin
					n.res = `MDC_RES_RING; // (R10)
					ev[`MDC_IRQ_RING] = 1'b1;
				end
				if (s.online && modem_ev_i.no_carrier) begin
					n.online = 1'b0;
					n.hold = 1'b0;
					n.res = `MDC_RES_LOST_CARRIER; // (R10)
					ev[`MDC_IRQ_ERR] = 1'b1;
				end else if (s.online && s.secs >= s.tmo) begin
					n.online = 1'b0; // (R11)
					n.hold = 1'b0;
					n.res = `MDC_RES_IDLE_HUP;
					ev[`MDC_IRQ_IDLE] = 1'b1;
				end
				if (!s.online || modem_ev_i.activity || start) begin
					sec_clr = 1'b1;
				end
			end
			FS_SEND: begin
				sec_clr = 1'b1;
				if (s.txv && tx_ready_i) begin
					n.txv = 1'b0;
					if (s.last) begin
						n.fsm = FS_WAIT;
					end
				end
			end
			FS_WAIT: begin
				// the idle timeout also bounds the wait for the modem's answer
				if (s.is_dial && modem_ev_i.connect) begin
					n.online = 1'b1;
					n.res = `MDC_RES_CONNECTED; // (R10)
					ev[`MDC_IRQ_CONN] = 1'b1;
				end else if (s.is_dial && modem_ev_i.no_dialtone) begin
					n.res = `MDC_RES_NO_DIALTONE; // (R10)
				end else if (s.is_dial && modem_ev_i.dial_fail) begin
					n.res = `MDC_RES_DIAL_FAIL; // (R10)
				end else if (s.is_dial && modem_ev_i.no_carrier) begin
					n.res = `MDC_RES_NO_CONN; // (R9)
				end else if (!s.is_dial && modem_ev_i.ok) begin
					n.res = `MDC_RES_OK; // (R9)
				end else if (!s.is_dial && modem_ev_i.error) begin
					n.res = `MDC_RES_BAD_CMD;
				end else if (s.secs >= s.tmo) begin
					n.res = `MDC_RES_NO_CONN; // (R9)
				end
				// a result equal to the previous one must still end the command
				fin = s.is_dial ? (modem_ev_i.connect || modem_ev_i.no_dialtone ||
					modem_ev_i.dial_fail || modem_ev_i.no_carrier) :
					(modem_ev_i.ok || modem_ev_i.error);
				if (fin || s.secs >= s.tmo) begin
					n.fsm = FS_IDLE;
					n.cmd = `MDC_CMD_IDLE;
					sec_clr = 1'b1;
					ev[`MDC_IRQ_DONE] = 1'b1;
					if (n.res != `MDC_RES_OK && n.res != `MDC_RES_CONNECTED) begin
						ev[`MDC_IRQ_ERR] = 1'b1;
						if (s.is_dial) begin
							n.hold = 1'b0;
						end
					end
				end
			end
			default: begin
				n.fsm = FS_IDLE;
			end
		endcase

		// load the next character when the stream starts or one is taken
		if (start || (s.fsm == FS_SEND && s.txv && tx_ready_i && !s.last)) begin
			b = step_byte(n, n.st);
			n.st = n.st + 6'd1;
			n.txv = 1'b1;
			if (b == 8'h00) begin
				// end of string; reading stops at the terminator (R5)
				n.txd = `MDC_CH_CR;
				n.last = 1'b1;
			end else begin
				n.txd = b; // (R8)
				n.last = 1'b0;
			end
		end

		if (sec_clr) begin
			n.secs = 10'h0;
		end

		// a new event wins over a write-one clear in the same cycle
		n.ist = (s.ist & ~w1c) | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.tmo <= `MDC_TMO_RST;
			s.tone <= `MDC_TONE_RST;
		end else begin
			s <= n;
		end
	end

	// ------------------------------------------------------------------
	// seconds base
	// ------------------------------------------------------------------
	mdc_tick #(
		.CYC_PER_SEC(CYC_PER_SEC)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(sec_clr),
		.tick_o(tick)
	);

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign wb_dat_o = s.rdat;
	assign wb_ack_o = s.ack;
	assign tx_data_o = s.txd;
	assign tx_valid_o = s.txv;
	assign line_hold_o = s.hold;
	assign tone_mode_o = s.tone;
	assign online_o = s.online;
	assign irq_o = |(s.ist & s.imask);
endmodule

// ---- bench/mdc_chk.sv ----
// concurrent checks on the ports of the modem dial control top
`timescale 1ns/100ps
`include "mdc_cfg.svh"

module mdc_chk
	import mdc_pkg::*;
#(
	parameter logic [31:0] CTRL_BASE = 32'h0000_0000
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_we_i, // bus write
	input wire logic [31:0] wb_adr_i, // bus address
	input wire logic wb_ack_o, // bus acknowledge
	input wire mdc_modem_ev_t modem_ev_i, // modem events
	input wire logic [7:0] tx_data_o, // character out
	input wire logic tx_valid_o, // character valid
	input wire logic tx_ready_i, // modem ready
	input wire logic line_hold_o, // line held
	input wire logic tone_mode_o, // tone dialling
	input wire logic online_o // connected
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !$past(wb_stb_i) |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	char_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("character dropped or changed before taken");
	char_gap_a: assert property (tx_valid_o && tx_ready_i && tx_data_o == `MDC_CH_CR
		|=> !tx_valid_o)
		else $error("valid not dropped after closing return");
	online_hold_a: assert property (online_o |-> line_hold_o)
		else $error("online without line held");
	online_cause_a: assert property ($rose(online_o) |-> $past(modem_ev_i.connect))
		else $error("online without connect event");
	tone_cause_a: assert property ($changed(tone_mode_o) |->
		$past(wb_we_i && wb_ack_o && wb_adr_i == CTRL_BASE + {20'h0, `MDC_OFF_CFG}))
		else $error("dial mode changed without config write");
endmodule

bind mdc_top mdc_chk #(.CTRL_BASE(CTRL_BASE)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_ack_o(wb_ack_o), .modem_ev_i(modem_ev_i), .tx_data_o(tx_data_o),
	.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .line_hold_o(line_hold_o),
	.tone_mode_o(tone_mode_o), .online_o(online_o));

// ---- bench/mdc_modem_model.sv ----
// behavioural modem: takes characters, answers after the closing return
`timescale 1ns/100ps
`include "mdc_cfg.svh"

module mdc_modem_model
	import mdc_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic [7:0] tx_data_i, // character in
	input wire logic tx_valid_i, // character valid
	output logic tx_ready_o, // character taken
	input wire logic slow_i, // stall on alternate cycles while valid
	input wire mdc_modem_ev_t reply_i, // answer to give
	output mdc_modem_ev_t ev_o // answer pulses
);
	logic [7:0] rx_q[$];
	logic [2:0] wait_r;
	logic stall_r;

	assign tx_ready_o = !(slow_i && stall_r);

	always @(posedge clk_i) begin
		ev_o <= '0;
		if (rst_i) begin
			stall_r <= 1'b1;
			wait_r <= 3'h0;
			rx_q.delete();
		end else begin
			if (tx_valid_i)
				stall_r <= ~stall_r;
			// characters kept exactly as offered
			if (tx_valid_i && tx_ready_o) begin
				rx_q.push_back(tx_data_i);
				if (tx_data_i == `MDC_CH_CR)
					wait_r <= 3'h4;
			end
			if (wait_r != 3'h0)
				wait_r <= wait_r - 3'h1;
			if (wait_r == 3'h1)
				ev_o <= reply_i;
		end
	end
endmodule

// ---- bench/mdc_top_tb.sv ----
// self-checking testbench for the modem dial control top
`timescale 1ns/100ps
`include "mdc_cfg.svh"

module mdc_top_tb
	import mdc_pkg::*;
;
	localparam logic [31:0] BASE = 32'h0000_1000;
	localparam int CPS = 20;
	logic clk_i, rst_i, cyc, stb, we, ack, slow, tx_valid, tx_ready, hold, tone, online, irq;
	logic [31:0] adr, wdat, rdat;
	logic [3:0] sel;
	logic [7:0] tx_data;
	mdc_modem_ev_t reply, ev;
	int n_errors, checks, cycles;

	mdc_top #(.CTRL_BASE(BASE), .CYC_PER_SEC(CPS)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .modem_ev_i(ev),
		.tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
		.line_hold_o(hold), .tone_mode_o(tone), .online_o(online), .irq_o(irq));
	mdc_modem_model modem_u (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data),
		.tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .slow_i(slow), .reply_i(reply),
		.ev_o(ev));

	// ----
	// bus and compare helpers
	// ----
	function automatic logic [31:0] a(input logic [11:0] o);
		return BASE + {20'h0, o};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wb_cyc(input logic w, input logic [31:0] ad, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= d; sel <= 4'h7;
		do @(posedge clk_i); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] o, input logic [31:0] d);
		logic [31:0] r;
		wb_cyc(1'b1, a(o), d, r);
	endtask
	task automatic rd_chk(input logic [11:0] o, input logic [31:0] e);
		logic [31:0] r;
		wb_cyc(1'b0, a(o), 32'h0, r);
		chk(r, e);
	endtask
	// strings must already sit in place before the command word goes out
	task automatic run_cmd(input logic [15:0] c, input string e, input logic [7:0] rp,
		input logic [15:0] x);
		logic [31:0] d;
		int i;
		reply <= mdc_modem_ev_t'(rp);
		modem_u.rx_q.delete();
		wr(`MDC_OFF_CMD, {16'h0, c});
		d = 32'h1;
		i = 0;
		while (d[15:0] !== 16'h0 && i < 300) begin
			wb_cyc(1'b0, a(`MDC_OFF_CMD), 32'h0, d);
			i++;
		end
		chk(d, 32'h0);
		rd_chk(`MDC_OFF_RES, {16'h0, x});
		chk(32'(modem_u.rx_q.size()), 32'(e.len()));
		for (i = 0; i < e.len(); i++)
			chk({24'h0, modem_u.rx_q[i]}, {24'h0, e[i]});
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rd_chk(`MDC_OFF_CMD, 32'h0);
		rd_chk(`MDC_OFF_CFG, 32'h0001_001E);
		rd_chk(12'h200, 32'h0);
		chk({31'h0, tone}, 32'h1);
	endtask
	task automatic t_dial_user;
		wr(`MDC_OFF_IMASK, 32'h1F);
		wr(`MDC_OFF_STR, 32'h0035);
		wr(12'h00C, 32'h0);
		wr(12'h010, 32'h3939);
		run_cmd(16'h000B, "ATDT5\015", 8'h20, 16'h0002);
		chk({30'h0, online, hold}, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wr(`MDC_OFF_IST, 32'h1F);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		run_cmd(16'h00FF, "", 8'h00, 16'h0000);
		chk({30'h0, online, hold}, 32'h0);
	endtask
	task automatic t_dial_slot;
		wr(`MDC_OFF_CFG, 32'h0000_0005);
		slow <= 1'b1;
		wr(12'h6D0, 32'h3231);
		wr(12'h6D4, 32'h0);
		run_cmd(16'h000A, "ATDP12\015", 8'h04, 16'h0067);
		chk({30'h0, tone, hold}, 32'h0);
		slow <= 1'b0;
	endtask
	task automatic t_init;
		string e;
		int i;
		wr(`MDC_OFF_SLOT, 32'h5441);
		wr(12'h404, 32'h0);
		run_cmd(16'h0065, "AT\015", 8'h80, 16'h0000);
		run_cmd(16'h0032, "", 8'h00, 16'h006A);
		e = "";
		for (i = 0; i < 20; i++) begin
			wr(`MDC_OFF_STR + 12'(4 * i), 32'h3030);
			e = {e, "00"};
		end
		run_cmd(16'h006F, {e, "\015"}, 8'h40, 16'h006A);
	endtask
	task automatic t_idle;
		int i;
		wr(`MDC_OFF_CFG, 32'h0000_02BC);
		rd_chk(`MDC_OFF_CFG, 32'h0000_0258);
		wr(`MDC_OFF_CFG, 32'h0000_0001);
		rd_chk(`MDC_OFF_CFG, 32'h0000_0005);
		run_cmd(16'h000A, "ATDP12\015", 8'h20, 16'h0002);
		i = 0;
		while (online === 1'b1 && i < 300) begin
			@(posedge clk_i);
			i++;
		end
		chk({31'h0, online}, 32'h0);
		rd_chk(`MDC_OFF_RES, 32'h0069);
	endtask

	// ----
	// run control
	// ----
	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// a hang costs one mismatch and still ends in the report
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out;
		end
	end
	initial begin
		rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; slow = 1'b0;
		adr = 32'h0; wdat = 32'h0; sel = 4'h0; reply = '0;
		n_errors = 0; checks = 0; cycles = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_dial_user;
		t_dial_slot;
		t_init;
		t_idle;
		close_out;
	end
endmodule
